//--- design/wec_defs.svh
// Offsets, bit positions, reset values and sizes of the wake event output block
`ifndef WEC_DEFS_SVH
`define WEC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets from the runtime block base
// ----------------------------------------------------------------------------
`define WEC_OFF_WAKE_STS 16'h0000
`define WEC_OFF_PB_STS 16'h0001
`define WEC_OFF_WAKE_EN 16'h0002
`define WEC_OFF_PB_EN 16'h0003

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WEC_BIT_FLAG 0
`define WEC_BIT_PB_SW_EN 0
`define WEC_BIT_PB_HW_EN 1
`define WEC_BIT_PB_HW_ARM 2

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define WEC_RST_BYTE 8'h00
`define WEC_RST_BIT 1'b0
`define WEC_DATA_W 8
`define WEC_ADDR_W 16
`define WEC_HW_EVT_N 3

`endif

//--- design/wec_pkg.sv
// Types shared by the wake event output block
package wec_pkg;

   // ----------------------------------------------------------------------------
   // Register select decoded from the I/O address
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      WEC_SEL_NONE = 3'h0,
      WEC_SEL_WAKE_STS = 3'h1,
      WEC_SEL_PB_STS = 3'h3,
      WEC_SEL_WAKE_EN = 3'h2,
      WEC_SEL_PB_EN = 3'h6
   } wec_sel_e;

   // ----------------------------------------------------------------------------
   // State of the top module
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic wake_en;
      logic pb_sw_en;
      logic pb_hw_arm;
      logic [2:0] hw_evt_prev;
      logic [7:0] rdata;
      logic wake_n;
      logic wake_oe;
      logic pb_n;
      logic pb_oe;
   } wec_top_s;

   // State of a sticky flag
   typedef struct packed {
      logic flag;
   } wec_flag_s;

endpackage

//--- design/wec_sync.sv
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`include "wec_defs.svh"

module wec_sync
   import wec_pkg::*;
#(
   parameter int WIDTH = `WEC_HW_EVT_N + 1
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   // ----------------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------------
   if (WIDTH < 1) begin : g_bad_width
      $error("wec_sync: WIDTH must be at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } wec_sync_s;

   wec_sync_s state_q;
   wec_sync_s state_d;

   // First stage feeds only the second stage
   always_comb begin
      state_d = state_q;
      if (ce_i) begin
         state_d.meta = async_i;
         state_d.stable = state_q.meta;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_o = state_q.stable;

endmodule

//--- design/wec_flag.sv
// Sticky status flag: hardware sets, software writes one to clear
`timescale 1ns/100ps
`include "wec_defs.svh"

module wec_flag
   import wec_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic init_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   wec_flag_s state_q;
   wec_flag_s state_d;

   // Init wins, then set wins over a clear in the same cycle
   always_comb begin
      state_d = state_q;
      if (ce_i) begin
         if (init_i) begin
            state_d.flag = `WEC_RST_BIT;
         end else if (set_i) begin
            state_d.flag = 1'b1;
         end else if (clr_i) begin
            state_d.flag = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign flag_o = state_q.flag;

endmodule

//--- design/wec_top.sv
// Wake event output control: status, enables and the two open-drain outputs
`timescale 1ns/100ps
`include "wec_defs.svh"

module wec_top
   import wec_pkg::*;
#(
   parameter int ADDR_W = `WEC_ADDR_W
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic standby_por_i,
   input wire logic [ADDR_W-1:0] runtime_block_base_i,
   input wire logic [ADDR_W-1:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   input wire logic wake_source_pending_i,
   input wire logic button_source_pending_i,
   input wire logic ac_power_loss_i,
   input wire logic button_override_i,
   input wire logic thermal_trip_i,
   output logic wake_request_out_n_o,
   output logic wake_request_out_oe_o,
   output logic power_button_out_n_o,
   output logic power_button_out_oe_o
);

   // ----------------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------------
   if (ADDR_W < 2 || ADDR_W > `WEC_ADDR_W) begin : g_bad_addr
      $error("wec_top: ADDR_W must lie between 2 and 16");
   end

   // ----------------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------------
   // True when the address hits base plus the given offset
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] base,
                                input logic [`WEC_ADDR_W-1:0] off);
      logic [ADDR_W-1:0] sum;
      sum = base + off[ADDR_W-1:0];
      return addr == sum;
   endfunction

   wec_sel_e sel;

   // One register select per access
   always_comb begin
      sel = WEC_SEL_NONE;
      if (hit(io_addr_i, runtime_block_base_i, `WEC_OFF_WAKE_STS)) begin
         sel = WEC_SEL_WAKE_STS;
      end else if (hit(io_addr_i, runtime_block_base_i, `WEC_OFF_PB_STS)) begin
         sel = WEC_SEL_PB_STS;
      end else if (hit(io_addr_i, runtime_block_base_i, `WEC_OFF_WAKE_EN)) begin
         sel = WEC_SEL_WAKE_EN;
      end else if (hit(io_addr_i, runtime_block_base_i, `WEC_OFF_PB_EN)) begin
         sel = WEC_SEL_PB_EN;
      end
   end

   // ----------------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------------
   logic [`WEC_HW_EVT_N:0] pins_sync;
   logic stby_init;
   logic [`WEC_HW_EVT_N-1:0] hw_evt;

   wec_sync #(
      .WIDTH(`WEC_HW_EVT_N + 1)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .async_i({standby_por_i, thermal_trip_i, button_override_i, ac_power_loss_i}),
      .sync_o(pins_sync)
   );

   assign stby_init = pins_sync[`WEC_HW_EVT_N];
   assign hw_evt = pins_sync[`WEC_HW_EVT_N-1:0];

   wec_top_s state_q;
   wec_top_s state_d;

   // ----------------------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------------------
   logic wake_sts;
   logic pb_sts;
   logic pb_hw_en;
   logic wr_wake_sts;
   logic wr_pb_sts;
   logic wr_pb_en;
   logic hw_rise;

   assign wr_wake_sts = io_wr_i && sel == WEC_SEL_WAKE_STS;
   assign wr_pb_sts = io_wr_i && sel == WEC_SEL_PB_STS;
   assign wr_pb_en = io_wr_i && sel == WEC_SEL_PB_EN;
   // A hardware event going active
   assign hw_rise = |(hw_evt & ~state_q.hw_evt_prev);

   wec_flag u_wake_sts (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .init_i(stby_init),
      .set_i(wake_source_pending_i),
      .clr_i(wr_wake_sts && io_wdata_i[`WEC_BIT_FLAG]),
      .flag_o(wake_sts)
   );

   wec_flag u_pb_sts (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .init_i(stby_init),
      .set_i(button_source_pending_i),
      .clr_i(wr_pb_sts && io_wdata_i[`WEC_BIT_FLAG]),
      .flag_o(pb_sts)
   );

   // Hardware enable survives standby reset
   wec_flag u_pb_hw_en (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .init_i(1'b0),
      .set_i(state_q.pb_hw_arm && hw_rise),
      .clr_i(wr_pb_en && io_wdata_i[`WEC_BIT_PB_HW_EN]),
      .flag_o(pb_hw_en)
   );

   // ----------------------------------------------------------------------------
   // Enables, read data and output drive
   // ----------------------------------------------------------------------------
   logic wake_drive;
   logic pb_drive;

   assign wake_drive = wake_sts && state_q.wake_en;
   assign pb_drive = pb_sts && (state_q.pb_sw_en || pb_hw_en);

   // Next state of enables, read data and outputs
   always_comb begin
      state_d = state_q;
      if (ce_i) begin
         state_d.hw_evt_prev = hw_evt;
         if (stby_init) begin
            state_d.wake_en = `WEC_RST_BIT;
         end else if (io_wr_i && sel == WEC_SEL_WAKE_EN) begin
            state_d.wake_en = io_wdata_i[`WEC_BIT_FLAG];
         end
         if (wr_pb_en) begin
            state_d.pb_sw_en = io_wdata_i[`WEC_BIT_PB_SW_EN];
            state_d.pb_hw_arm = io_wdata_i[`WEC_BIT_PB_HW_ARM];
         end
         if (io_rd_i) begin
            state_d.rdata = `WEC_RST_BYTE;
            unique case (sel)
               WEC_SEL_WAKE_STS: state_d.rdata[`WEC_BIT_FLAG] = wake_sts;
               WEC_SEL_PB_STS: state_d.rdata[`WEC_BIT_FLAG] = pb_sts;
               WEC_SEL_WAKE_EN: state_d.rdata[`WEC_BIT_FLAG] = state_q.wake_en;
               WEC_SEL_PB_EN: begin
                  state_d.rdata[`WEC_BIT_PB_SW_EN] = state_q.pb_sw_en;
                  state_d.rdata[`WEC_BIT_PB_HW_EN] = pb_hw_en;
                  state_d.rdata[`WEC_BIT_PB_HW_ARM] = state_q.pb_hw_arm;
               end
               WEC_SEL_NONE: state_d.rdata = `WEC_RST_BYTE;
            endcase
         end
         // Open drain: pull low while driving
         state_d.wake_oe = wake_drive;
         state_d.wake_n = ~wake_drive;
         state_d.pb_oe = pb_drive;
         state_d.pb_n = ~pb_drive;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= '{wake_en: `WEC_RST_BIT, pb_sw_en: `WEC_RST_BIT,
                      pb_hw_arm: `WEC_RST_BIT, hw_evt_prev: '0,
                      rdata: `WEC_RST_BYTE, wake_n: 1'b1, wake_oe: 1'b0,
                      pb_n: 1'b1, pb_oe: 1'b0};
      end else begin
         state_q <= state_d;
      end
   end

   assign io_rdata_o = state_q.rdata;
   assign wake_request_out_n_o = state_q.wake_n;
   assign wake_request_out_oe_o = state_q.wake_oe;
   assign power_button_out_n_o = state_q.pb_n;
   assign power_button_out_oe_o = state_q.pb_oe;

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_wake_clear;
      ce_i && !stby_init && !wake_source_pending_i && wr_wake_sts
         && io_wdata_i[`WEC_BIT_FLAG];
   endsequence

   sequence s_pb_clear;
      ce_i && !stby_init && !button_source_pending_i && wr_pb_sts
         && io_wdata_i[`WEC_BIT_FLAG];
   endsequence

   chk_wake_sets: assert property (
      ce_i && !stby_init && wake_source_pending_i |=> wake_sts)
      else $error("wake flag not set by event");

   chk_wake_w1c: assert property (
      s_wake_clear ##1 (ce_i && !wake_source_pending_i && !stby_init)
         |=> !wake_request_out_oe_o)
      else $error("wake output still driven after clear");

   chk_wake_w0: assert property (
      ce_i && !stby_init && wr_wake_sts && !io_wdata_i[`WEC_BIT_FLAG] && wake_sts
         |=> wake_sts)
      else $error("writing zero changed wake flag");

   chk_stby_clears: assert property (
      ce_i && stby_init |=> !wake_sts && !pb_sts && !state_q.wake_en)
      else $error("standby reset left status set");

   chk_wake_gate: assert property (
      ce_i |=> wake_request_out_oe_o == $past(wake_drive)
         && wake_request_out_n_o == !$past(wake_drive))
      else $error("wake output does not follow flag and enable");

   chk_pb_sets: assert property (
      ce_i && !stby_init && button_source_pending_i |=> pb_sts)
      else $error("button flag not set by event");

   chk_pb_w1c: assert property (
      s_pb_clear |=> !pb_sts)
      else $error("button flag not cleared by write one");

   chk_pb_drive: assert property (
      ce_i |=> power_button_out_oe_o == $past(pb_drive))
      else $error("button output does not follow flag and enables");

   chk_hw_arm_off: assert property (
      ce_i && !state_q.pb_hw_arm && !wr_pb_en |=> pb_hw_en == $past(pb_hw_en))
      else $error("hw enable moved while unarmed");

   chk_hw_set: assert property (
      ce_i && state_q.pb_hw_arm && hw_rise |=> pb_hw_en)
      else $error("hw enable not set by armed event");

   chk_en_keep: assert property (
      ce_i && stby_init && !wr_pb_en |=> state_q.pb_sw_en == $past(state_q.pb_sw_en))
      else $error("button enable lost on standby reset");

   chk_reserved_rd: assert property (
      ce_i && io_rd_i |=> io_rdata_o[7:3] == 5'h00)
      else $error("reserved read bits not zero");

   chk_wake_off: assert property (
      ce_i && !state_q.wake_en |=> !wake_request_out_oe_o)
      else $error("wake output driven with enable off");

   chk_pb_off: assert property (
      ce_i && !state_q.pb_sw_en && !pb_hw_en |=> !power_button_out_oe_o)
      else $error("button output driven with both enables off");

   chk_pb_release: assert property (
      s_pb_clear ##1 (ce_i && !button_source_pending_i && !stby_init)
         |=> !power_button_out_oe_o)
      else $error("button output still driven after clear");

   chk_hw_clear: assert property (
      ce_i && !(state_q.pb_hw_arm && hw_rise) && wr_pb_en
         && io_wdata_i[`WEC_BIT_PB_HW_EN] |=> !pb_hw_en)
      else $error("hw enable not cleared by write one");

   chk_wake_en_wr: assert property (
      ce_i && !stby_init && io_wr_i && sel == WEC_SEL_WAKE_EN
         |=> state_q.wake_en == $past(io_wdata_i[`WEC_BIT_FLAG]))
      else $error("wake enable write not taken");

endmodule

//--- test/wec_evt_model.sv
// Chipset side model that raises wake, button and hardware events
`timescale 1ns/100ps

module wec_evt_model (
   input wire logic sys_clk_i,
   output logic wake_source_pending_o,
   output logic button_source_pending_o,
   output logic ac_power_loss_o,
   output logic button_override_o,
   output logic thermal_trip_o
);
   logic [2:0] hw_pins;

   // Quiet levels from time zero
   initial begin
      wake_source_pending_o = 1'b0;
      button_source_pending_o = 1'b0;
      hw_pins = 3'h0;
   end

   // Pin order: power loss, override, thermal trip
   assign ac_power_loss_o = hw_pins[0];
   assign button_override_o = hw_pins[1];
   assign thermal_trip_o = hw_pins[2];

   // A source status seen for one cycle, then cleared by software
   task automatic wake_event();
      @(negedge sys_clk_i);
      wake_source_pending_o = 1'b1;
      @(negedge sys_clk_i);
      wake_source_pending_o = 1'b0;
   endtask

   // An event already gated by the per-source button enables
   task automatic button_event();
      @(negedge sys_clk_i);
      button_source_pending_o = 1'b1;
      @(negedge sys_clk_i);
      button_source_pending_o = 1'b0;
   endtask

   // Hardware pin held active for a chosen time, quick or slow
   task automatic hw_event(input int idx, input int hold);
      @(negedge sys_clk_i);
      hw_pins[idx] = 1'b1;
      repeat (hold) @(negedge sys_clk_i);
      hw_pins[idx] = 1'b0;
      repeat (4) @(negedge sys_clk_i);
   endtask
endmodule

//--- test/testbench.sv
// Self-checking bench of the wake event output control block
`timescale 1ns/100ps
`include "wec_defs.svh"

module testbench
   import wec_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic standby_por_i = 1'b0;
   logic ce = 1'b1;
   logic [15:0] base = 16'h0A00;
   logic [15:0] io_addr = 16'h0000;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic wake_pend, btn_pend, ac_loss, override, trip;
   logic wake_n, wake_oe, pb_n, pb_oe;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   // 20 MHz clock
   always #25 sys_clk_i = ~sys_clk_i;

   wec_evt_model u_evt (
      .sys_clk_i(sys_clk_i),
      .wake_source_pending_o(wake_pend),
      .button_source_pending_o(btn_pend),
      .ac_power_loss_o(ac_loss),
      .button_override_o(override),
      .thermal_trip_o(trip)
   );

   wec_top u_dut (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce),
      .standby_por_i(standby_por_i),
      .runtime_block_base_i(base),
      .io_addr_i(io_addr),
      .io_wr_i(io_wr),
      .io_rd_i(io_rd),
      .io_wdata_i(io_wdata),
      .io_rdata_o(io_rdata),
      .wake_source_pending_i(wake_pend),
      .button_source_pending_i(btn_pend),
      .ac_power_loss_i(ac_loss),
      .button_override_i(override),
      .thermal_trip_i(trip),
      .wake_request_out_n_o(wake_n),
      .wake_request_out_oe_o(wake_oe),
      .power_button_out_n_o(pb_n),
      .power_button_out_oe_o(pb_oe)
   );

   // ----------------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [15:0] off, input logic [7:0] d);
      @(negedge sys_clk_i);
      io_addr = base + off;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge sys_clk_i);
      io_wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] off, input logic [7:0] exp);
      @(negedge sys_clk_i);
      io_addr = base + off;
      io_rd = 1'b1;
      @(negedge sys_clk_i);
      io_rd = 1'b0;
      @(negedge sys_clk_i);
      chk(io_rdata, exp);
   endtask

   // Open-drain outputs: enable and level must agree
   task automatic chk_out(input logic w, input logic p);
      chk({6'h00, wake_oe, pb_oe}, {6'h00, w, p});
      chk({6'h00, wake_n, pb_n}, {6'h00, ~w, ~p});
   endtask

   // ----------------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------------
   task automatic t_reset();
      rd_reg(`WEC_OFF_WAKE_STS, 8'h00);
      rd_reg(`WEC_OFF_PB_STS, 8'h00);
      rd_reg(`WEC_OFF_WAKE_EN, 8'h00);
      rd_reg(`WEC_OFF_PB_EN, 8'h00);
      chk_out(1'b0, 1'b0);
   endtask

   task automatic t_wake();
      u_evt.wake_event();
      rd_reg(`WEC_OFF_WAKE_STS, 8'h01);
      chk_out(1'b0, 1'b0);
      wr_reg(`WEC_OFF_WAKE_STS, 8'h00);
      rd_reg(`WEC_OFF_WAKE_STS, 8'h01);
      wr_reg(`WEC_OFF_WAKE_EN, 8'hFF);
      rd_reg(`WEC_OFF_WAKE_EN, 8'h01);
      chk_out(1'b1, 1'b0);
      wr_reg(`WEC_OFF_WAKE_STS, 8'hFF);
      repeat (2) @(negedge sys_clk_i);
      chk_out(1'b0, 1'b0);
      rd_reg(`WEC_OFF_WAKE_STS, 8'h00);
   endtask

   task automatic t_button();
      wr_reg(`WEC_OFF_PB_EN, 8'h01);
      u_evt.button_event();
      rd_reg(`WEC_OFF_PB_STS, 8'h01);
      chk_out(1'b0, 1'b1);
      wr_reg(`WEC_OFF_PB_EN, 8'h00);
      repeat (2) @(negedge sys_clk_i);
      chk_out(1'b0, 1'b0);
      wr_reg(`WEC_OFF_PB_STS, 8'h00);
      rd_reg(`WEC_OFF_PB_STS, 8'h01);
      wr_reg(`WEC_OFF_PB_STS, 8'h01);
      rd_reg(`WEC_OFF_PB_STS, 8'h00);
   endtask

   task automatic t_hw();
      u_evt.hw_event(0, 3);
      rd_reg(`WEC_OFF_PB_EN, 8'h00);
      for (int i = 0; i < `WEC_HW_EVT_N; i++) begin
         wr_reg(`WEC_OFF_PB_EN, 8'h04);
         u_evt.hw_event(i, 2 + 4 * i);
         rd_reg(`WEC_OFF_PB_EN, 8'h06);
         wr_reg(`WEC_OFF_PB_EN, 8'h04);
         rd_reg(`WEC_OFF_PB_EN, 8'h06);
         wr_reg(`WEC_OFF_PB_EN, 8'h06);
         rd_reg(`WEC_OFF_PB_EN, 8'h04);
      end
      u_evt.hw_event(2, 2);
      u_evt.button_event();
      repeat (2) @(negedge sys_clk_i);
      chk_out(1'b0, 1'b1);
      wr_reg(`WEC_OFF_PB_EN, 8'hFA);
      rd_reg(`WEC_OFF_PB_EN, 8'h00);
      chk_out(1'b0, 1'b0);
      wr_reg(`WEC_OFF_PB_STS, 8'h01);
   endtask

   task automatic t_standby();
      wr_reg(`WEC_OFF_WAKE_EN, 8'h01);
      wr_reg(`WEC_OFF_PB_EN, 8'h05);
      u_evt.wake_event();
      u_evt.button_event();
      repeat (2) @(negedge sys_clk_i);
      chk_out(1'b1, 1'b1);
      standby_por_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      standby_por_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      rd_reg(`WEC_OFF_WAKE_STS, 8'h00);
      rd_reg(`WEC_OFF_PB_STS, 8'h00);
      rd_reg(`WEC_OFF_WAKE_EN, 8'h00);
      rd_reg(`WEC_OFF_PB_EN, 8'h05);
      chk_out(1'b0, 1'b0);
   endtask

   task automatic t_base();
      base = 16'h0C20;
      rd_reg(`WEC_OFF_PB_EN, 8'h05);
      rd_reg(16'h0004, 8'h00);
      rd_reg(16'h0A03 - 16'h0C20, 8'h00);
      wr_reg(16'h0006, 8'hFF);
      rd_reg(`WEC_OFF_WAKE_EN, 8'h00);
   endtask

   // Clock enable low: writes and events must leave no trace
   task automatic t_freeze();
      ce = 1'b0;
      wr_reg(`WEC_OFF_WAKE_EN, 8'h01);
      u_evt.wake_event();
      ce = 1'b1;
      rd_reg(`WEC_OFF_WAKE_STS, 8'h00);
      rd_reg(`WEC_OFF_WAKE_EN, 8'h00);
      chk_out(1'b0, 1'b0);
   endtask

   task automatic stop_test();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      repeat (3) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      t_reset();
      t_wake();
      t_button();
      t_hw();
      t_standby();
      t_base();
      t_freeze();
      stop_test();
   end
endmodule
